// [rtl/port_f_gpio_bank.sv]
`timescale 1ns/1ns
// Port F general purpose I/O register bank with a classic Wishbone slave.
module port_f_gpio_bank (
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        ce_i,
  input  wire logic        idle_i,
  input  wire logic        cyc_i,
  input  wire logic        stb_i,
  input  wire logic        we_i,
  input  wire logic [15:0] adr_i,
  input  wire logic [3:0]  sel_i,
  input  wire logic [31:0] dat_i,
  output logic      [31:0] dat_o,
  output logic             ack_o,
  input  wire logic [15:0] pin_i,
  output logic      [15:0] pin_out_o,
  output logic      [15:0] pin_oe_n_o,
  output logic      [15:0] analog_o,
  output logic      [15:0] pull_up_o,
  output logic      [15:0] pull_down_o,
  output logic             irq_o
);

  logic [15:0] analog_select_f;
  logic [15:0] direction_f;
  logic [15:0] output_latch_f;
  logic [15:0] open_drain_f;
  logic [15:0] pull_up_f;
  logic [15:0] pull_down_f;
  logic [15:0] change_notice_ctrl_f;
  logic [15:0] change_notice_enable_f;
  logic [15:0] change_notice_status_f;
  logic [15:0] irq_mask;
  logic [15:0] pin_meta;
  logic [15:0] pin_level_f;
  logic [15:0] pin_prev;
  logic [15:0] pin_direct;

  logic                       req;
  logic                       wr_stb;
  logic [15:0]                base;
  logic [3:0]                 alias_sel;
  logic                       alias_ok;
  gpio_bank_pkg::write_op_t   kind;
  logic [15:0]                lane_mask;
  logic [15:0]                cn_events;
  logic                       cn_run;
  logic [31:0]                next_dat;

  logic [15:0] next_analog;
  logic [15:0] next_direction;
  logic [15:0] next_latch;
  logic [15:0] next_open_drain;
  logic [15:0] next_pull_up;
  logic [15:0] next_pull_down;
  logic [15:0] next_cn_ctrl;
  logic [15:0] next_cn_enable;
  logic [15:0] next_status_w1c;
  logic [15:0] next_irq_mask;

  // Byte enables for the low halfword; upper lanes hold nothing.
  function automatic logic [15:0] lanes(input logic [3:0] sel);
    lanes = {{8{sel[1]}}, {8{sel[0]}}};
  endfunction

  function automatic logic hit(input logic [15:0] b, input logic [15:0] off);
    hit = (b == off);
  endfunction

  assign req       = cyc_i & stb_i & ~ack_o;
  assign base      = adr_i & gpio_bank_pkg::REG_BASE_MASK;
  assign alias_sel = adr_i[3:0];
  assign alias_ok  = (alias_sel == gpio_bank_pkg::ALIAS_NONE) ||
                     (alias_sel == gpio_bank_pkg::ALIAS_CLR) ||
                     (alias_sel == gpio_bank_pkg::ALIAS_SET) ||
                     (alias_sel == gpio_bank_pkg::ALIAS_INV);
  assign wr_stb    = req & we_i & ce_i & alias_ok;
  assign lane_mask = lanes(sel_i);

  always_comb begin
    case (alias_sel)
      gpio_bank_pkg::ALIAS_CLR: kind = gpio_bank_pkg::OP_CLEAR;
      gpio_bank_pkg::ALIAS_SET: kind = gpio_bank_pkg::OP_SET;
      gpio_bank_pkg::ALIAS_INV: kind = gpio_bank_pkg::OP_INVERT;
      default:                  kind = gpio_bank_pkg::OP_WRITE;
    endcase
  end

  gpio_reg_update u_upd_analog (
    .op_i        (lane_mask),
    .cur_i       (analog_select_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_analog)
  );

  gpio_reg_update u_upd_direction (
    .op_i        (lane_mask),
    .cur_i       (direction_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_direction)
  );

  gpio_reg_update u_upd_latch (
    .op_i        (lane_mask),
    .cur_i       (output_latch_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_latch)
  );

  gpio_reg_update u_upd_open_drain (
    .op_i        (lane_mask),
    .cur_i       (open_drain_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_open_drain)
  );

  gpio_reg_update u_upd_pull_up (
    .op_i        (lane_mask),
    .cur_i       (pull_up_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_pull_up)
  );

  gpio_reg_update u_upd_pull_down (
    .op_i        (lane_mask),
    .cur_i       (pull_down_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_pull_down)
  );

  gpio_reg_update u_upd_cn_ctrl (
    .op_i        (lane_mask),
    .cur_i       (change_notice_ctrl_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::CN_CTRL_MASK),
    .kind_i      (kind),
    .next_o      (next_cn_ctrl)
  );

  gpio_reg_update u_upd_cn_enable (
    .op_i        (lane_mask),
    .cur_i       (change_notice_enable_f),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_cn_enable)
  );

  gpio_reg_update u_upd_irq_mask (
    .op_i        (lane_mask),
    .cur_i       (irq_mask),
    .wdata_i     (dat_i[15:0]),
    .impl_mask_i (gpio_bank_pkg::PIN_IMPL_MASK),
    .kind_i      (kind),
    .next_o      (next_irq_mask)
  );

  // Pins are asynchronous, so two flip-flops sit before any reader.
  // No reset here: the sampled pin level has no defined value until it settles.
  always_ff @(posedge clk_i) begin
    if (ce_i) begin
      pin_meta    <= pin_i;
      pin_direct  <= pin_meta;
    end
  end

  assign pin_level_f = pin_direct & gpio_bank_pkg::PIN_IMPL_MASK;

  // Change notice stops while idle when the halt bit is set.
  assign cn_run    = change_notice_ctrl_f[gpio_bank_pkg::CN_CTRL_ON_BIT] &
                     ~(idle_i & change_notice_ctrl_f[gpio_bank_pkg::CN_CTRL_IDLE_BIT]);
  assign cn_events = (pin_level_f ^ pin_prev) & change_notice_enable_f & {16{cn_run}};

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      analog_select_f <= gpio_bank_pkg::RST_ANALOG_SELECT;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_ANALOG_SELECT)) begin
      analog_select_f <= next_analog;
    end
  end

  // Direction resets to all inputs so no pin is driven before software asks for it.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      direction_f <= gpio_bank_pkg::RST_DIRECTION;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_DIRECTION)) begin
      direction_f <= next_direction;
    end
  end

  // The latch deliberately has no reset; software must load it before enabling outputs.
  always_ff @(posedge clk_i) begin
    if (wr_stb && (hit(base, gpio_bank_pkg::OFF_OUTPUT_LATCH) ||
                   hit(base, gpio_bank_pkg::OFF_PIN_LEVEL))) begin
      output_latch_f <= next_latch;
    end
  end

  // One block per register keeps each write decode next to the flop it feeds.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      open_drain_f <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_OPEN_DRAIN)) begin
      open_drain_f <= next_open_drain;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pull_up_f <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_PULL_UP)) begin
      pull_up_f <= next_pull_up;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pull_down_f <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_PULL_DOWN)) begin
      pull_down_f <= next_pull_down;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_notice_ctrl_f <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_CN_CTRL)) begin
      change_notice_ctrl_f <= next_cn_ctrl;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_notice_enable_f <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_CN_ENABLE)) begin
      change_notice_enable_f <= next_cn_enable;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_mask <= gpio_bank_pkg::RST_ZERO;
    end else if (wr_stb && hit(base, gpio_bank_pkg::OFF_IRQ_MASK)) begin
      irq_mask <= next_irq_mask;
    end
  end

  // Status is read-only apart from write-one-to-clear at its base; a new edge wins.
  assign next_status_w1c = (wr_stb && hit(base, gpio_bank_pkg::OFF_CN_STATUS) &&
                            kind == gpio_bank_pkg::OP_WRITE) ?
                           (dat_i[15:0] & lane_mask) : gpio_bank_pkg::RST_ZERO;

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      change_notice_status_f <= gpio_bank_pkg::RST_ZERO;
    end else if (ce_i) begin
      change_notice_status_f <= (change_notice_status_f & ~next_status_w1c) | cn_events;
    end
  end

  // The previous level keeps following the pins while change notice is off,
  // so switching it on later does not report stale edges.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_prev <= gpio_bank_pkg::RST_ZERO;
    end else if (ce_i) begin
      pin_prev <= pin_level_f;
    end
  end

  always_comb begin
    next_dat = 32'h0000_0000;
    if (alias_sel == gpio_bank_pkg::ALIAS_NONE) begin
      case (base)
        gpio_bank_pkg::OFF_ANALOG_SELECT: next_dat[15:0] = analog_select_f;
        gpio_bank_pkg::OFF_DIRECTION:     next_dat[15:0] = direction_f;
        gpio_bank_pkg::OFF_PIN_LEVEL:     next_dat[15:0] = pin_level_f;
        gpio_bank_pkg::OFF_OUTPUT_LATCH:  next_dat[15:0] = output_latch_f;
        gpio_bank_pkg::OFF_OPEN_DRAIN:    next_dat[15:0] = open_drain_f;
        gpio_bank_pkg::OFF_PULL_UP:       next_dat[15:0] = pull_up_f;
        gpio_bank_pkg::OFF_PULL_DOWN:     next_dat[15:0] = pull_down_f;
        gpio_bank_pkg::OFF_CN_CTRL:       next_dat[15:0] = change_notice_ctrl_f;
        gpio_bank_pkg::OFF_CN_ENABLE:     next_dat[15:0] = change_notice_enable_f;
        gpio_bank_pkg::OFF_CN_STATUS:     next_dat[15:0] = change_notice_status_f;
        gpio_bank_pkg::OFF_IRQ_MASK:      next_dat[15:0] = irq_mask;
        default:                          next_dat = 32'h0000_0000;
      endcase
    end
  end

  // One wait state: ack follows the edge that takes the request; aliases read zero.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else if (ce_i) begin
      ack_o <= req;
      dat_o <= req ? next_dat : 32'h0000_0000;
    end
  end

  // Open-drain pins drive only low; a high latch bit floats the pin.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pin_out_o   <= gpio_bank_pkg::RST_ZERO;
      pin_oe_n_o  <= 16'hffff;
      analog_o    <= gpio_bank_pkg::RST_ANALOG_SELECT;
      pull_up_o   <= gpio_bank_pkg::RST_ZERO;
      pull_down_o <= gpio_bank_pkg::RST_ZERO;
    end else if (ce_i) begin
      pin_out_o   <= output_latch_f & ~open_drain_f;
      pin_oe_n_o  <= direction_f | ~gpio_bank_pkg::PIN_IMPL_MASK |
                     (open_drain_f & output_latch_f);
      analog_o    <= analog_select_f;
      pull_up_o   <= pull_up_f;
      pull_down_o <= pull_down_f;
    end
  end

  // The interrupt is a registered level, so it trails its status bit by one cycle.
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      irq_o <= 1'b0;
    end else if (ce_i) begin
      irq_o <= |(change_notice_status_f & irq_mask);
    end
  end

endmodule // port_f_gpio_bank

// [rtl/gpio_bank_pkg.sv]
// Package with register map, field layout and reset values of the port F I/O bank.
package gpio_bank_pkg;

  localparam int          DATA_W = 32;
  localparam int          PIN_W  = 16;
  localparam int          ADDR_W = 16;

  localparam logic [15:0] OFF_ANALOG_SELECT     = 16'h6500;
  localparam logic [15:0] OFF_DIRECTION         = 16'h6510;
  localparam logic [15:0] OFF_PIN_LEVEL         = 16'h6520;
  localparam logic [15:0] OFF_OUTPUT_LATCH      = 16'h6530;
  localparam logic [15:0] OFF_OPEN_DRAIN        = 16'h6540;
  localparam logic [15:0] OFF_PULL_UP           = 16'h6550;
  localparam logic [15:0] OFF_PULL_DOWN         = 16'h6560;
  localparam logic [15:0] OFF_CN_CTRL           = 16'h6570;
  localparam logic [15:0] OFF_CN_ENABLE         = 16'h6580;
  localparam logic [15:0] OFF_CN_STATUS         = 16'h6590;
  localparam logic [15:0] OFF_IRQ_MASK          = 16'h65a0;

  localparam logic [15:0] REG_BASE_MASK         = 16'hfff0;
  localparam logic [3:0]  ALIAS_CLR             = 4'h4;
  localparam logic [3:0]  ALIAS_SET             = 4'h8;
  localparam logic [3:0]  ALIAS_INV             = 4'hc;
  localparam logic [3:0]  ALIAS_NONE            = 4'h0;

  localparam logic [15:0] PIN_IMPL_MASK         = 16'h313f;
  localparam logic [15:0] RST_ANALOG_SELECT     = 16'h3107;
  localparam logic [15:0] RST_DIRECTION         = 16'h313f;
  localparam logic [15:0] RST_ZERO              = 16'h0000;

  localparam int          CN_CTRL_ON_BIT        = 15;
  localparam int          CN_CTRL_IDLE_BIT      = 13;
  localparam logic [15:0] CN_CTRL_MASK          = 16'ha000;

  typedef enum logic [1:0] {
    OP_WRITE,
    OP_CLEAR,
    OP_SET,
    OP_INVERT
  } write_op_t;

endpackage

// [rtl/gpio_reg_update.sv]
`timescale 1ns/1ns
// Combinational next-value logic for one register under plain, clear, set or invert writes.
module gpio_reg_update (
  input  wire logic [15:0]                op_i,
  input  wire logic [15:0]                cur_i,
  input  wire logic [15:0]                wdata_i,
  input  wire logic [15:0]                impl_mask_i,
  input  wire gpio_bank_pkg::write_op_t   kind_i,
  output logic      [15:0]                next_o
);

  logic [15:0] next_raw;

  always_comb begin
    case (kind_i)
      gpio_bank_pkg::OP_CLEAR:  next_raw = cur_i & ~wdata_i;
      gpio_bank_pkg::OP_SET:    next_raw = cur_i | wdata_i;
      gpio_bank_pkg::OP_INVERT: next_raw = cur_i ^ wdata_i;
      default:                  next_raw = wdata_i;
    endcase
  end

  // Only bits marked in op_i are touched; unimplemented bits stay zero.
  assign next_o = ((next_raw & op_i) | (cur_i & ~op_i)) & impl_mask_i;

endmodule // gpio_reg_update

// [sim/port_f_gpio_bank_assertions.sv]
// Concurrent checks on the port F bank bus and pin outputs.
`timescale 1ns/1ns
module port_f_gpio_bank_assertions (
  input wire logic        clk_i,
  input wire logic        rst_i,
  input wire logic        ce_i,
  input wire logic        cyc_i,
  input wire logic        stb_i,
  input wire logic        we_i,
  input wire logic [15:0] adr_i,
  input wire logic [3:0]  sel_i,
  input wire logic [31:0] dat_i,
  input wire logic [31:0] dat_o,
  input wire logic        ack_o,
  input wire logic [15:0] pin_oe_n_o,
  input wire logic [15:0] analog_o,
  input wire logic [15:0] pull_up_o,
  input wire logic [15:0] pull_down_o,
  input wire logic        irq_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  wire take = cyc_i && stb_i && ce_i && !ack_o;

  take_ack_a: assert property (take |=> ack_o)
    else $error("no ack after request");
  ack_pulse_a: assert property (ack_o && ce_i |=> !ack_o)
    else $error("ack longer than one cycle");
  upper_zero_a: assert property (ack_o |-> dat_o[31:16] == 16'h0000)
    else $error("upper halfword not zero");
  unimpl_read_a: assert property (ack_o && (adr_i & 16'hfff0) != 16'h6570 |->
    (dat_o[15:0] & ~16'h313f) == 16'h0000) else $error("unimplemented bit read as one");
  ctrl_read_a: assert property (ack_o && (adr_i & 16'hfff0) == 16'h6570 |->
    (dat_o[15:0] & ~16'ha000) == 16'h0000) else $error("unimplemented control bit read as one");
  alias_read_a: assert property (take && !we_i && adr_i[3:0] != 4'h0 |=> dat_o == 0)
    else $error("alias read not zero");
  no_drive_a: assert property ((~pin_oe_n_o & ~16'h313f) == 16'h0000)
    else $error("missing pin driven");
  analog_rst_a: assert property (disable iff (1'b0) (rst_i && ce_i)[*2] |=> analog_o == 16'h3107)
    else $error("analog select reset wrong");
  dir_rst_a: assert property (disable iff (1'b0) (rst_i && ce_i)[*2] |=> pin_oe_n_o == 16'hffff)
    else $error("pins driven in reset");
  zero_rst_a: assert property (disable iff (1'b0) (rst_i && ce_i)[*2] |=>
    pull_up_o == 0 && pull_down_o == 0 && !irq_o) else $error("pull or irq reset wrong");
  set_alias_a: assert property (take && we_i && adr_i == 16'h6558 && sel_i == 4'hf ##1 ce_i
    |=> pull_up_o == ($past(pull_up_o) | ($past(dat_i[15:0], 2) & 16'h313f)))
    else $error("set alias result wrong");

  cover property (take && we_i);
  cover property (take && !we_i && adr_i[3:0] != 4'h0);
  cover property ($rose(irq_o));
  cover property (!ce_i ##1 ce_i);
endmodule // port_f_gpio_bank_assertions

bind port_f_gpio_bank port_f_gpio_bank_assertions u_chk (.clk_i, .rst_i, .ce_i, .cyc_i,
  .stb_i, .we_i, .adr_i, .sel_i, .dat_i, .dat_o, .ack_o, .pin_oe_n_o, .analog_o, .pull_up_o,
  .pull_down_o, .irq_o);

// [sim/port_f_gpio_bank_tb_top.sv]
// Self-checking bench for the port F I/O register bank.
`timescale 1ns/1ns
module port_f_gpio_bank_tb_top;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ce_i = 1'b1;
  logic        idle_i = 1'b0;
  logic        cyc_i = 1'b0;
  logic        stb_i = 1'b0;
  logic        we_i = 1'b0;
  logic [15:0] adr_i = 16'h0000;
  logic [3:0]  sel_i = 4'h0;
  logic [31:0] dat_i = 32'h0000_0000;
  logic [15:0] pin_i = 16'h0000;
  logic [31:0] dat_o;
  logic        ack_o;
  logic [15:0] pin_out_o;
  logic [15:0] pin_oe_n_o;
  logic [15:0] analog_o;
  logic [15:0] pull_up_o;
  logic [15:0] pull_down_o;
  logic        irq_o;
  logic [31:0] rd;
  int          err_count = 0;
  int          checks = 0;

  port_f_gpio_bank u_dut (.clk_i, .rst_i, .ce_i, .idle_i, .cyc_i, .stb_i, .we_i, .adr_i,
    .sel_i, .dat_i, .dat_o, .ack_o, .pin_i, .pin_out_o, .pin_oe_n_o, .analog_o, .pull_up_o,
    .pull_down_o, .irq_o);

  initial forever #5 clk_i = ~clk_i;

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask

  // Holds the request until ack is sampled; a missing ack fails the ack compare.
  task automatic bus(input logic wr, input logic [15:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_i);
    cyc_i <= 1'b1;
    stb_i <= 1'b1;
    we_i  <= wr;
    adr_i <= a;
    sel_i <= 4'hf;
    dat_i <= d;
    do begin
      @(posedge clk_i);
      n++;
    end while (ack_o !== 1'b1 && n < 20);
    chk("ack", 32'h1, {31'h0, ack_o});
    rd = dat_o;
    cyc_i <= 1'b0;
    stb_i <= 1'b0;
  endtask

  task automatic rdchk(input logic [15:0] a, input logic [31:0] exp);
    bus(1'b0, a, 32'h0000_0000);
    chk($sformatf("read %h", a), exp, rd);
  endtask

  task automatic t_reset();
    logic [15:0] zeros [8] = '{16'h6540, 16'h6550, 16'h6560, 16'h6570, 16'h6580, 16'h6590,
                               16'h65a0, 16'h6600};
    rdchk(16'h6500, 32'h0000_3107);
    rdchk(16'h6510, 32'h0000_313f);
    foreach (zeros[i]) rdchk(zeros[i], 32'h0000_0000);
    $display("reset test done");
  endtask

  task automatic t_alias();
    bus(1'b1, 16'h6550, 32'hffff_ffff);
    rdchk(16'h6550, 32'h0000_313f);
    bus(1'b1, 16'h6554, 32'h0000_0101);
    rdchk(16'h6550, 32'h0000_303e);
    bus(1'b1, 16'h6558, 32'h0000_01c0);
    rdchk(16'h6550, 32'h0000_313e);
    bus(1'b1, 16'h655c, 32'h0000_1003);
    rdchk(16'h6558, 32'h0000_0000);
    chk("pull_up_o", 32'h0000_213d, {16'h0000, pull_up_o});
    chk("pull_down_o", 32'h0000_0000, {16'h0000, pull_down_o});
    bus(1'b1, 16'h6568, 32'h0000_00f5);
    rdchk(16'h6560, 32'h0000_0035);
    chk("pull_down_o", 32'h0000_0035, {16'h0000, pull_down_o});
    bus(1'b1, 16'h6504, 32'h0000_ffff);
    rdchk(16'h6500, 32'h0000_0000);
    chk("analog_o", 32'h0000_0000, {16'h0000, analog_o});
    $display("alias test done");
  endtask

  task automatic t_pins();
    bus(1'b1, 16'h6510, 32'h0000_0000);
    bus(1'b1, 16'h6530, 32'h0000_3105);
    rdchk(16'h6530, 32'h0000_3105);
    chk("pin_out_o", 32'h0000_3105, {16'h0000, pin_out_o});
    chk("pin_oe_n_o", 32'h0000_cec0, {16'h0000, pin_oe_n_o});
    bus(1'b1, 16'h6548, 32'h0000_0001);
    rdchk(16'h6540, 32'h0000_0001);
    chk("pin_out_o", 32'h0000_3104, {16'h0000, pin_out_o});
    chk("pin_oe_n_o", 32'h0000_cec1, {16'h0000, pin_oe_n_o});
    pin_i <= 16'hffff;
    repeat (4) @(posedge clk_i);
    rdchk(16'h6520, 32'h0000_313f);
    $display("pin test done");
  endtask

  task automatic t_irq();
    bus(1'b1, 16'h6570, 32'hffff_ffff);
    rdchk(16'h6570, 32'h0000_a000);
    bus(1'b1, 16'h6580, 32'h0000_0001);
    bus(1'b1, 16'h65a0, 32'h0000_0001);
    pin_i <= 16'hfffe;
    for (int i = 0; i < 10 && irq_o !== 1'b1; i++) @(posedge clk_i);
    chk("irq_o", 32'h1, {31'h0, irq_o});
    rdchk(16'h6590, 32'h0000_0001);
    bus(1'b1, 16'h6590, 32'h0000_0001);
    rdchk(16'h6590, 32'h0000_0000);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    bus(1'b1, 16'h65a4, 32'h0000_0001);
    pin_i <= 16'hffff;
    repeat (6) @(posedge clk_i);
    rdchk(16'h6590, 32'h0000_0001);
    chk("irq_o", 32'h0, {31'h0, irq_o});
    bus(1'b1, 16'h6600, 32'hffff_ffff);
    rdchk(16'h6600, 32'h0000_0000);
    $display("irq test done");
  endtask

  // Idle halt of change notice, then a pin pulse hidden by a low clock enable.
  task automatic t_halt();
    bus(1'b1, 16'h6590, 32'h0000_0001);
    idle_i <= 1'b1;
    pin_i  <= 16'hfffe;
    repeat (6) @(posedge clk_i);
    rdchk(16'h6590, 32'h0000_0000);
    bus(1'b1, 16'h6574, 32'h0000_2000);
    rdchk(16'h6570, 32'h0000_8000);
    pin_i <= 16'hffff;
    repeat (6) @(posedge clk_i);
    rdchk(16'h6590, 32'h0000_0001);
    bus(1'b1, 16'h6590, 32'h0000_0001);
    ce_i  <= 1'b0;
    pin_i <= 16'hfffe;
    repeat (4) @(posedge clk_i);
    pin_i <= 16'hffff;
    repeat (2) @(posedge clk_i);
    ce_i   <= 1'b1;
    idle_i <= 1'b0;
    repeat (4) @(posedge clk_i);
    rdchk(16'h6590, 32'h0000_0000);
    $display("halt test done");
  endtask

  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_count);
    if (err_count == 0 && checks > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    #200000;
    err_count++;
    stop_test();
  end

  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 1'b0;
    t_reset();
    t_alias();
    t_pins();
    t_irq();
    t_halt();
    stop_test();
  end
endmodule // port_f_gpio_bank_tb_top
